// [hw/flow_through_burst_sram.sv]
// Flow-through burst memory, 256K words of 18 bits, common data bus
// Contract
// - Every synchronous input is registered on the rising clock edge.
// - Clock qualifier high freezes all state, extending the previous cycle.
// - Reads and writes run back to back with no wait cycles.
// - Two active-low lane selects, qualified by write, each enables its lane.
// - Writes complete internally, timed by the clock, no external pulse.
// - Three synchronous chip selects decide select or deselect on a load.
// - Data drivers are off during every write data cycle.
// - Sampled address picks exactly one of 256K words.
// - Low two address bits load the burst counter.
// - Burst steps in linear or interleaved order.
// - One 18-bit bus carries read and write data.
// - Read data reaches the bus in the access cycle, no output stage.
// - Active-low output enable gates drivers without waiting for a clock.
// - Drive direction is decided internally even with output enable held low.
// - Advance high steps the counter except when idle, low loads a new address when selected.
// - Selects one and three active low, two active high, all needed.
// - Output enable masked in write data cycle and when deselected.
`timescale 1ns/1ns
`default_nettype none
module flow_through_burst_sram
    import fts_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Access control
    input wire logic CLOCK_QUALIFIER_N,
    input wire logic WRITE_CMD_N,
    input wire logic ADVANCE_OR_LOAD,
    input wire logic BURST_ORDER_LINEAR,
    input wire logic [LANES-1:0] LANE_WRITE_SEL_N,
    // Chip selects
    input wire logic CHIP_SEL_LOW_FIRST,
    input wire logic CHIP_SEL_HIGH,
    input wire logic CHIP_SEL_LOW_SECOND,
    // Address
    input wire logic [ADDR_W-1:0] ADDR,
    // Data bus
    input wire logic OUTPUT_EN_N,
    input wire logic [DATA_W-1:0] DQ_I,
    output logic [DATA_W-1:0] DQ_O,
    output logic DQ_OE
);
    burst_if bi ();

    logic [DATA_W-1:0] mem [WORDS];
    op_t op_r, op_nxt;
    logic [BASE_W-1:0] base_r, base_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [LANES-1:0] wr_lane_r, wr_lane_nxt;
    logic [DATA_W-1:0] dq_out_r, dq_out_nxt;
    logic drive_r, drive_nxt;
    logic en, sel, load;
    op_t acc_op;
    logic [ADDR_W-1:0] acc_addr;
    logic [DATA_W-1:0] rd_word;

    // one qualifier gates every edge of state below
    assign en = !CLOCK_QUALIFIER_N;
    assign sel = !CHIP_SEL_LOW_FIRST && CHIP_SEL_HIGH && !CHIP_SEL_LOW_SECOND;
    // advance low loads a new access
    assign load = !ADVANCE_OR_LOAD;

    // Burst counter hookup
    assign bi.en = en;
    assign bi.load = load && sel;
    assign bi.advance = ADVANCE_OR_LOAD && (op_r != OP_IDLE);
    assign bi.linear = BURST_ORDER_LINEAR;
    assign bi.start = ADDR[LOW_W-1:0];

    burst_counter u_cnt (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .bi(bi)
    );

    // Decode the access presented at this edge
    always_comb begin
        acc_op = op_r;
        acc_addr = {base_r, bi.low_next};
        // selects only matter on a load
        if (load) begin
            // write command low writes, otherwise read
            acc_op = !sel ? OP_IDLE : (WRITE_CMD_N ? OP_READ : OP_WRITE);
            // full address taken on a load
            acc_addr = ADDR;
        end
    end

    // Read word with forwarding, since the write landing at this edge is not yet in the array
    always_comb begin
        rd_word = mem[acc_addr];
        if (wr_pend_r && (wr_addr_r == acc_addr)) begin
            for (int i = 0; i < LANES; i++) begin
                if (wr_lane_r[i]) begin
                    rd_word[i*LANE_W +: LANE_W] = DQ_I[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Next values of the access pipeline
    // one access per enabled edge
    always_comb begin
        op_nxt = op_r;
        base_nxt = base_r;
        wr_pend_nxt = wr_pend_r;
        wr_addr_nxt = wr_addr_r;
        wr_lane_nxt = wr_lane_r;
        dq_out_nxt = dq_out_r;
        drive_nxt = drive_r;
        if (en) begin
            op_nxt = acc_op;
            // high bits change only on a load
            if (load && sel) begin
                base_nxt = ADDR[ADDR_W-1:LOW_W];
            end
            // lane selects count only for a write
            wr_pend_nxt = (acc_op == OP_WRITE);
            wr_addr_nxt = acc_addr;
            wr_lane_nxt = (acc_op == OP_WRITE) ? ~LANE_WRITE_SEL_N : '0;
            // read word registered at the edge, on the bus within this cycle
            dq_out_nxt = (acc_op == OP_READ) ? rd_word : dq_out_r;
            // drive only for reads; off for write and deselect
            drive_nxt = (acc_op == OP_READ);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            op_r <= OP_IDLE;
            base_r <= '0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= ADDR_RESET;
            wr_lane_r <= '0;
            dq_out_r <= DQ_RESET;
            drive_r <= 1'b0;
        end else begin
            op_r <= op_nxt;
            base_r <= base_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_lane_r <= wr_lane_nxt;
            dq_out_r <= dq_out_nxt;
            drive_r <= drive_nxt;
        end
    end

    // write data taken one edge after its command, per lane; array has no reset
    always_ff @(posedge CORE_CLK) begin
        if (en && wr_pend_r) begin
            for (int i = 0; i < LANES; i++) begin
                if (wr_lane_r[i]) begin
                    mem[wr_addr_r][i*LANE_W +: LANE_W] <= DQ_I[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // one bus out; output enable acts without a clock
    assign DQ_O = dq_out_r;
    assign DQ_OE = drive_r && !OUTPUT_EN_N;

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    chk_freeze_holds: assert property (CLOCK_QUALIFIER_N |=> $stable(DQ_O) && $stable(drive_r) && $stable(op_r))
        else $error("state moved while clock qualifier high");
    chk_write_quiet: assert property (en && acc_op == OP_WRITE |=> !DQ_OE)
        else $error("driving during write data cycle");
    chk_read_each: assert property (en && acc_op == OP_READ |=> drive_r && DQ_O == $past(rd_word))
        else $error("read word missing in access cycle");
    chk_oe_async: assert property (OUTPUT_EN_N |-> !DQ_OE)
        else $error("driving with output enable high");
    chk_desel_off: assert property (en && load && !sel |=> !drive_r ##1 (drive_r -> !$past(CLOCK_QUALIFIER_N)))
        else $error("driving after deselect");
    chk_addr_load: assert property (en && load && sel |=> {base_r, bi.low} == $past(ADDR))
        else $error("loaded address wrong");
    chk_burst_base: assert property (en && ADVANCE_OR_LOAD |=> $stable(base_r))
        else $error("high address bits moved in burst");
    // Order checks need the order pin steady over both edges, since it may change mid-burst
    chk_linear_step: assert property (en && bi.advance && BURST_ORDER_LINEAR ##1 BURST_ORDER_LINEAR
        |-> bi.low == $past(bi.low_next))
        else $error("burst step wrong");
    chk_interleave_step: assert property (en && bi.advance && !BURST_ORDER_LINEAR ##1 !BURST_ORDER_LINEAR
        |-> bi.low == $past(bi.low_next))
        else $error("interleaved burst step wrong");
    // Each lane alone: the other lane must keep its old contents
    chk_lane_write: assert property (en && wr_pend_r && wr_lane_r[0] && !wr_lane_r[1]
        |=> mem[$past(wr_addr_r)][LANE_W-1:0] == $past(DQ_I[LANE_W-1:0])
            && mem[$past(wr_addr_r)][DATA_W-1:LANE_W] == $past(mem[wr_addr_r][DATA_W-1:LANE_W]))
        else $error("lane write wrong");
    chk_lane_upper: assert property (en && wr_pend_r && wr_lane_r[1] && !wr_lane_r[0]
        |=> mem[$past(wr_addr_r)][DATA_W-1:LANE_W] == $past(DQ_I[DATA_W-1:LANE_W])
            && mem[$past(wr_addr_r)][LANE_W-1:0] == $past(mem[wr_addr_r][LANE_W-1:0]))
        else $error("upper lane write wrong");
    // Full word lands one enabled edge after its command, with no outside pulse
    chk_write_commit: assert property (en && wr_pend_r && wr_lane_r == 2'h3
        |=> mem[$past(wr_addr_r)] == $past(DQ_I))
        else $error("write word did not land");
    chk_freeze_state: assert property (CLOCK_QUALIFIER_N |=> $stable(base_r) && $stable(wr_pend_r) && $stable(wr_addr_r))
        else $error("access state moved while clock qualifier high");
    chk_desel_nowrite: assert property (en && acc_op == OP_IDLE |=> !wr_pend_r)
        else $error("write scheduled by idle cycle");
    chk_oe_follows: assert property (!OUTPUT_EN_N |-> DQ_OE == drive_r)
        else $error("drive enable differs from internal direction");

    cov_read: cover property (en && acc_op == OP_READ ##1 en && acc_op == OP_WRITE);
    cov_write_read: cover property (en && acc_op == OP_WRITE ##1 en && acc_op == OP_READ && acc_addr == wr_addr_r);
    cov_burst: cover property (en && load && sel ##1 (en && ADVANCE_OR_LOAD)[*3]);
    cov_freeze: cover property (en && acc_op == OP_WRITE ##1 CLOCK_QUALIFIER_N ##1 en);
    cov_interleave: cover property (en && bi.advance && !BURST_ORDER_LINEAR);
endmodule
`default_nettype wire

// [hw/fts_pkg.sv]
// Shared constants and types for the flow-through burst memory
package fts_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 18;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int WORDS = 262144;
    localparam int LOW_W = 2;
    localparam int BASE_W = ADDR_W - LOW_W;
    localparam logic [DATA_W-1:0] DQ_RESET = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
    localparam logic [LOW_W-1:0] LOW_ONE = 2'h1;
    localparam logic [LOW_W-1:0] LOW_RESET = 2'h0;

    // Gray along idle -> read -> write
    typedef enum logic [1:0] {
        OP_IDLE = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h3
    } op_t;
endpackage

// [hw/burst_if.sv]
// Link between the access control and the burst counter
`timescale 1ns/1ns
`default_nettype none
interface burst_if;
    import fts_pkg::*;
    logic en;
    logic load;
    logic advance;
    logic linear;
    logic [LOW_W-1:0] start;
    logic [LOW_W-1:0] low;
    logic [LOW_W-1:0] low_next;

    modport ctl (output en, output load, output advance, output linear, output start, input low, input low_next);
    modport cnt (input en, input load, input advance, input linear, input start, output low, output low_next);
endinterface
`default_nettype wire

// [hw/burst_counter.sv]
// Two-bit burst counter with linear and interleaved order
`timescale 1ns/1ns
`default_nettype none
module burst_counter
    import fts_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control from the access logic
    burst_if.cnt bi
);
    logic [LOW_W-1:0] start_r, start_nxt;
    logic [LOW_W-1:0] step_r, step_nxt;
    logic [LOW_W-1:0] step_inc;

    // Offset into the group; start is kept so interleave can xor against it
    always_comb begin
        step_inc = step_r + LOW_ONE;
        start_nxt = start_r;
        step_nxt = step_r;
        if (bi.en && bi.load) begin
            start_nxt = bi.start;
            step_nxt = LOW_RESET;
        end else if (bi.en && bi.advance) begin
            step_nxt = step_inc;
        end
    end

    always_comb begin
        bi.low = bi.linear ? start_r + step_r : start_r ^ step_r;
        bi.low_next = bi.linear ? start_r + step_inc : start_r ^ step_inc;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_r <= LOW_RESET;
            step_r <= LOW_RESET;
        end else begin
            start_r <= start_nxt;
            step_r <= step_nxt;
        end
    end
endmodule
`default_nettype wire

// [verification/ctl_model.sv]
// Controller side of the shared data lines, resolving who drives them
`timescale 1ns/1ns
`default_nettype none
module ctl_model
    import fts_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write data offered by the controller
    input wire logic wr_drive,
    input wire logic [DATA_W-1:0] wr_data,
    // Device pins
    input wire logic [DATA_W-1:0] dq_o,
    input wire logic dq_oe,
    output logic [DATA_W-1:0] dq_i,
    output logic clash
);
    logic [DATA_W-1:0] last_r = DQ_RESET;
    // data held through the edge
    // A released bus shows the inverse of its last level, never a stale match
    always_comb begin
        if (dq_oe) dq_i = dq_o;
        else if (wr_drive) dq_i = wr_data;
        else dq_i = ~last_r;
        clash = dq_oe & wr_drive;
    end
    // Remember the last level seen on the lines
    always_ff @(posedge clk) last_r <= dq_i;
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the flow-through burst memory
`timescale 1ns/1ns
`default_nettype none
module tb;
    import fts_pkg::*;
    typedef struct packed {
        logic [2:0] sel;
        logic wn;
        logic adv;
        logic lin;
        logic [LANES-1:0] lanes;
        logic [ADDR_W-1:0] addr;
        logic wde;
        logic [DATA_W-1:0] wd;
        logic oe;
        logic [DATA_W-1:0] dq;
    } row_t;
    // Selects as first, high, second: 3'h2 selects, others deselect
    localparam row_t ROWS[17] = '{
        '{3'h2,1'h0,1'h0,1'h1,2'h0,18'h2F104,1'h0,18'h00000,1'h0,18'h00000},
        '{3'h2,1'h0,1'h1,1'h1,2'h0,18'h2F104,1'h1,18'h11111,1'h0,18'h00000},
        '{3'h2,1'h0,1'h1,1'h1,2'h0,18'h2F104,1'h1,18'h22222,1'h0,18'h00000},
        '{3'h2,1'h0,1'h1,1'h1,2'h0,18'h2F104,1'h1,18'h33333,1'h0,18'h00000},
        '{3'h2,1'h0,1'h0,1'h1,2'h1,18'h2F107,1'h1,18'h3FFFF,1'h0,18'h00000},
        '{3'h2,1'h1,1'h0,1'h0,2'h3,18'h2F105,1'h1,18'h00000,1'h1,18'h22222},
        '{3'h2,1'h1,1'h1,1'h0,2'h3,18'h2F105,1'h0,18'h00000,1'h1,18'h11111},
        '{3'h2,1'h1,1'h1,1'h0,2'h3,18'h2F105,1'h0,18'h00000,1'h1,18'h001FF},
        '{3'h2,1'h1,1'h1,1'h0,2'h3,18'h2F105,1'h0,18'h00000,1'h1,18'h33333},
        '{3'h2,1'h1,1'h0,1'h1,2'h3,18'h2F106,1'h0,18'h00000,1'h1,18'h33333},
        '{3'h2,1'h1,1'h1,1'h1,2'h3,18'h2F106,1'h0,18'h00000,1'h1,18'h001FF},
        '{3'h2,1'h1,1'h1,1'h1,2'h3,18'h2F106,1'h0,18'h00000,1'h1,18'h11111},
        '{3'h2,1'h1,1'h1,1'h1,2'h3,18'h2F106,1'h0,18'h00000,1'h1,18'h22222},
        '{3'h0,1'h1,1'h0,1'h1,2'h3,18'h2F104,1'h0,18'h00000,1'h0,18'h00000},
        '{3'h2,1'h1,1'h1,1'h1,2'h3,18'h2F104,1'h0,18'h00000,1'h0,18'h00000},
        '{3'h6,1'h1,1'h0,1'h1,2'h3,18'h2F104,1'h0,18'h00000,1'h0,18'h00000},
        '{3'h3,1'h1,1'h0,1'h1,2'h3,18'h2F104,1'h0,18'h00000,1'h0,18'h00000}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic qn = 1'b0;
    logic oen = 1'b0;
    logic [2:0] sel = 3'h5;
    logic wn = 1'b1;
    logic adv = 1'b0;
    logic lin = 1'b1;
    logic wde = 1'b0;
    logic [LANES-1:0] lanes = 2'h3;
    logic [ADDR_W-1:0] addr = ADDR_RESET;
    logic [DATA_W-1:0] wd = DQ_RESET;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] dq_i;
    logic dq_oe;
    logic clash;
    int err_total = 0;
    int n_checks = 0;
    // Free-running core clock
    always #5 clk = ~clk;
    flow_through_burst_sram i_dut (.CORE_CLK(clk), .RST_B(rst_b), .CLOCK_QUALIFIER_N(qn), .WRITE_CMD_N(wn),
        .ADVANCE_OR_LOAD(adv), .BURST_ORDER_LINEAR(lin), .LANE_WRITE_SEL_N(lanes), .CHIP_SEL_LOW_FIRST(sel[2]),
        .CHIP_SEL_HIGH(sel[1]), .CHIP_SEL_LOW_SECOND(sel[0]), .ADDR(addr), .OUTPUT_EN_N(oen), .DQ_I(dq_i),
        .DQ_O(dq_o), .DQ_OE(dq_oe));
    ctl_model i_ctl (.clk(clk), .wr_drive(wde), .wr_data(wd), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
        .clash(clash));
    task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Present one cycle, let its edge land; write data stays up through the edge only
    task step(input row_t r);
        {sel, wn, adv, lin, lanes, addr, wde, wd} = r[$bits(row_t)-1:DATA_W+1];
        @(posedge clk);
        wde <= 1'b0;
        #1;
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Both parties driving the lines at once is a fault
    always @(negedge clk) if (clash === 1'b1) check(dq_oe, 18'h00000);
    // Bound on the whole run
    initial begin
        #100000;
        err_total++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        check(dq_oe, 18'h00000);
        check(dq_o, DQ_RESET);
        rst_b = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 17; i++) begin
            step(ROWS[i]);
            check(dq_oe, ROWS[i].oe);
            if (ROWS[i].oe) check(dq_o, ROWS[i].dq);
        end
        $display("test rows done");
        step(row_t'{3'h2,1'h1,1'h0,1'h1,2'h3,18'h2F104,1'h0,18'h00000,1'h0,18'h00000});
        check(dq_o, 18'h11111);
        qn = 1'b1;
        step(row_t'{3'h2,1'h1,1'h0,1'h1,2'h3,18'h2F105,1'h0,18'h00000,1'h0,18'h00000});
        check(dq_o, 18'h11111);
        check(dq_oe, 18'h00001);
        oen = 1'b1;
        #1;
        check(dq_oe, 18'h00000);
        @(posedge clk);
        #1;
        oen = 1'b0;
        #1;
        check(dq_oe, 18'h00001);
        @(posedge clk);
        #1;
        qn = 1'b0;
        $display("test freeze and enable done");
        step(row_t'{3'h2,1'h0,1'h0,1'h1,2'h2,18'h2F104,1'h0,18'h00000,1'h0,18'h00000});
        check(dq_oe, 18'h00000);
        step(row_t'{3'h2,1'h1,1'h0,1'h1,2'h3,18'h2F104,1'h1,18'h00000,1'h0,18'h00000});
        check(dq_o, 18'h11000);
        $display("test turnaround done");
        // The array itself must hold the lane write, not only the forwarding path
        step(row_t'{3'h2,1'h1,1'h0,1'h1,2'h3,18'h2F104,1'h0,18'h00000,1'h0,18'h00000});
        check(dq_o, 18'h11000);
        check(dq_oe, 18'h00001);
        // Reset in mid-run clears the pipeline but leaves the array alone
        rst_b = 1'b0;
        #1;
        check(dq_oe, 18'h00000);
        check(dq_o, DQ_RESET);
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        step(row_t'{3'h2,1'h1,1'h0,1'h1,2'h3,18'h2F104,1'h0,18'h00000,1'h0,18'h00000});
        check(dq_o, 18'h11000);
        check(dq_oe, 18'h00001);
        $display("test reset again done");
        results();
    end
endmodule
`default_nettype wire
